/* File: logic/ddsc_pkg.sv */
/*
  Shared constants and types of the dual-channel converter control block:
  serial word layout, channel record, register offsets and reset values.
  Assumes a single 125 MHz system clock samples every pin.
*/
`default_nettype none

package ddsc_pkg;

  // ****************************************************************
  // Serial word layout
  // ****************************************************************
  localparam int WORD_W    = 16;
  localparam int CODE_W    = 12;
  localparam int CNT_W     = 5;
  localparam int CH_BIT    = 15;
  localparam int RANGE_BIT = 14;
  localparam int MODE_HI   = 13;
  localparam int MODE_LO   = 12;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;

  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_HIZ    = 2'h3;

  // ****************************************************************
  // Register map (byte addresses) and reset values
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IN_A   = 8'h08;
  localparam logic [7:0] OFS_IN_B   = 8'h0C;
  localparam logic [7:0] OFS_OUT_A  = 8'h10;
  localparam logic [7:0] OFS_OUT_B  = 8'h14;
  localparam int CTRL_LOAD_BIT = 0;
  localparam int CTRL_SEN_BIT  = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;

  typedef struct packed {
    logic              range;
    logic              pwr_mode_hi;
    logic              pwr_mode_lo;
    logic [CODE_W-1:0] code;
  } ddsc_chan_t;

  localparam ddsc_chan_t CHAN_RST = '0;

  typedef enum logic [1:0] {
    SER_IDLE,
    SER_SHIFT,
    SER_DONE
  } ddsc_ser_t;

endpackage : ddsc_pkg

`default_nettype wire

/* File: logic/ddsc_top.sv */
/*
  Digital control of a dual voltage-output converter: three-wire serial
  write port, double-buffered channel registers, load, clear and hard
  power-down pins, and an AHB-Lite register slave for supervision.
  Assumes all pins are asynchronous to CLOCK and that the serial clock
  runs well below a quarter of CLOCK.
*/
// Overview of operation
// - Reset clears channel registers, range 0, normal mode; serial enable set
// - Clear pin low zeroes all channel registers
// - Sixteen-bit shift register, bit 15 first
// - Bit 15 selects channel A or B
// - Bit 14 sets addressed channel range
// - Bits 13..12 set addressed channel power mode
// - Low twelve bits code; narrow variant drops two
// - Code is unsigned straight binary
// - Bits accepted only while frame select low
// - Shift one bit per falling serial edge
// - Ignore edges past sixteenth until new frame
// - Complete word copied into selected input register
// - Early frame end abandons word, inputs kept
// - Load low or soft load: outputs follow inputs; else hold
// - Output updates only if input newly written
// - Serial inputs disabled after word until fall
// - Power-down never alters register contents
// - Hard power-down pin forces both outputs hiz
`timescale 1ns/1ps
`default_nettype none

module ddsc_top #(
  parameter int DATA_BITS = 12
) (
  input  wire logic                 CLOCK,
  input  wire logic                 RST_B,
  input  wire logic                 HSEL,
  input  wire logic [31:0]          HADDR,
  input  wire logic [1:0]           HTRANS,
  input  wire logic                 HWRITE,
  input  wire logic [2:0]           HSIZE,
  input  wire logic [31:0]          HWDATA,
  input  wire logic                 HREADY,
  output logic      [31:0]          HRDATA,
  output logic                      HREADYOUT,
  output logic                      HRESP,
  input  wire logic                 FRAME_N,
  input  wire logic                 SCLK_IN,
  input  wire logic                 SDATA_IN,
  input  wire logic                 LOAD_OUTPUTS_N,
  input  wire logic                 CLEAR_ALL_N,
  input  wire logic                 HARD_POWERDOWN_N,
  output ddsc_pkg::ddsc_chan_t      OUT_CHAN_A,
  output ddsc_pkg::ddsc_chan_t      OUT_CHAN_B,
  output logic      [1:0]           PWR_MODE_A,
  output logic      [1:0]           PWR_MODE_B
);
  import ddsc_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic ddsc_chan_t word_to_chan(
    input logic [WORD_W-1:0] w
  );
    ddsc_chan_t c;
    c.range       = w[RANGE_BIT];
    c.pwr_mode_hi = w[MODE_HI];
    c.pwr_mode_lo = w[MODE_LO];
    c.code        = w[CODE_W-1:0];
    // Bit loop avoids a negative slice in the full-width variant
    for (int i = 0; i < CODE_W; i++) begin
      if (i < CODE_W - DATA_BITS) begin
        c.code[i] = 1'b0;
      end
    end
    return c;
  endfunction : word_to_chan

  function automatic logic [1:0] eff_mode(
    input ddsc_chan_t c,
    input logic       hard_pd
  );
    return hard_pd ? MODE_HIZ : {c.pwr_mode_hi, c.pwr_mode_lo};
  endfunction : eff_mode

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [5:1] pin_s1_q;
  logic [5:1] pin_s2_q;
  logic       sclk_s3_q;
  logic       frm_low;
  logic       sclk_fall;
  logic       din_s;
  logic       load_low;
  logic       hard_pd;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pin_s1_q  <= 5'h1F;
      pin_s2_q  <= 5'h1F;
      sclk_s3_q <= 1'b1;
    end else begin
      pin_s1_q  <= {FRAME_N, SCLK_IN, SDATA_IN, LOAD_OUTPUTS_N,
                    HARD_POWERDOWN_N};
      pin_s2_q  <= pin_s1_q;
      sclk_s3_q <= pin_s2_q[4];
    end
  end

  assign frm_low   = ~pin_s2_q[5];
  assign sclk_fall = sclk_s3_q & ~pin_s2_q[4];
  assign din_s     = pin_s2_q[3];
  assign load_low  = ~pin_s2_q[2];
  assign hard_pd   = ~pin_s2_q[1];

  // Clear acts at once as a second asynchronous reset of the channel
  // registers, but releases through two flops so that no register
  // leaves reset close to a clock edge.
  logic       clr_raw_n;
  logic [1:0] clr_sync_q;
  logic       chan_rst_n;

  assign clr_raw_n = RST_B & CLEAR_ALL_N;

  always_ff @(posedge CLOCK or negedge clr_raw_n) begin
    if (!clr_raw_n) begin
      clr_sync_q <= 2'h0;
    end else begin
      clr_sync_q <= {clr_sync_q[0], 1'b1};
    end
  end

  assign chan_rst_n = clr_sync_q[1];

  // ****************************************************************
  // Control register (bus side)
  // ****************************************************************
  logic       soft_load_q;
  logic       ser_en_q;
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       addr_ok;

  assign addr_ok = HSEL & HTRANS[1] & HREADY;

  // ****************************************************************
  // Serial receiver
  // ****************************************************************
  ddsc_ser_t          ser_q;
  logic [CNT_W-1:0]   cnt_q;
  logic [WORD_W-1:0]  shreg_q;
  logic [WORD_W-1:0]  word;
  logic               commit;

  assign word   = {shreg_q[WORD_W-2:0], din_s};
  assign commit = (ser_q == SER_SHIFT) & frm_low & sclk_fall
                  & (cnt_q == LAST_BIT);

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ser_q   <= SER_IDLE;
      cnt_q   <= '0;
      shreg_q <= '0;
    end else begin
      unique case (ser_q)
        SER_IDLE: begin
          cnt_q <= '0;
          if (frm_low && ser_en_q) begin
            ser_q <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          if (!frm_low) begin
            ser_q <= SER_IDLE;
          end else if (sclk_fall) begin
            shreg_q <= word;
            cnt_q   <= cnt_q + 5'h01;
            if (cnt_q == LAST_BIT) begin
              ser_q <= SER_DONE;
            end
          end
        end
        SER_DONE: begin
          // Inputs gated off; only a new frame start reopens them
          if (!frm_low) begin
            ser_q <= SER_IDLE;
          end
        end
        // Unused fourth code falls back to idle
        default: begin
          ser_q <= SER_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Input registers and pending flags
  // ****************************************************************
  ddsc_chan_t in_a_q;
  ddsc_chan_t in_b_q;
  ddsc_chan_t out_a_q;
  ddsc_chan_t out_b_q;
  logic       dirty_a_q;
  logic       dirty_b_q;
  logic       load_act;

  assign load_act = load_low | soft_load_q;

  always_ff @(posedge CLOCK or negedge chan_rst_n) begin
    if (!chan_rst_n) begin
      in_a_q <= CHAN_RST;
      in_b_q <= CHAN_RST;
    end else if (commit) begin
      if (word[CH_BIT]) begin
        in_b_q <= word_to_chan(word);
      end else begin
        in_a_q <= word_to_chan(word);
      end
    end
  end

  // A new word wins over the clear caused by a same-cycle transfer
  always_ff @(posedge CLOCK or negedge chan_rst_n) begin
    if (!chan_rst_n) begin
      dirty_a_q <= 1'b0;
      dirty_b_q <= 1'b0;
    end else begin
      if (commit && !word[CH_BIT]) begin
        dirty_a_q <= 1'b1;
      end else if (load_act) begin
        dirty_a_q <= 1'b0;
      end
      if (commit && word[CH_BIT]) begin
        dirty_b_q <= 1'b1;
      end else if (load_act) begin
        dirty_b_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge CLOCK or negedge chan_rst_n) begin
    if (!chan_rst_n) begin
      out_a_q <= CHAN_RST;
      out_b_q <= CHAN_RST;
    end else if (load_act) begin
      if (dirty_a_q) begin
        out_a_q <= in_a_q;
      end
      if (dirty_b_q) begin
        out_b_q <= in_b_q;
      end
    end
  end

  assign OUT_CHAN_A = out_a_q;
  assign OUT_CHAN_B = out_b_q;

  // Mode override only touches the output, never stored state
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      PWR_MODE_A <= MODE_NORMAL;
      PWR_MODE_B <= MODE_NORMAL;
    end else begin
      PWR_MODE_A <= eff_mode(out_a_q, hard_pd);
      PWR_MODE_B <= eff_mode(out_b_q, hard_pd);
    end
  end

  // ****************************************************************
  // AHB-Lite slave, zero wait states
  // ****************************************************************
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    unique case (a)
      OFS_CTRL:   rd_mux = {30'h0000_0000, ser_en_q, soft_load_q};
      OFS_STATUS: rd_mux = {24'h00_0000, dirty_b_q, dirty_a_q,
                            ser_q, hard_pd, cnt_q[2:0]};
      OFS_IN_A:   rd_mux = {17'h0_0000, in_a_q};
      OFS_IN_B:   rd_mux = {17'h0_0000, in_b_q};
      OFS_OUT_A:  rd_mux = {17'h0_0000, out_a_q};
      OFS_OUT_B:  rd_mux = {17'h0_0000, out_b_q};
      default:    rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      wr_pend_q <= addr_ok & HWRITE;
      if (addr_ok) begin
        wr_addr_q <= HADDR[7:0];
        HRDATA    <= HWRITE ? 32'h0000_0000 : rd_mux(HADDR[7:0]);
      end
    end
  end

  // Soft load is a one-cycle pulse; serial enable is a plain level
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      soft_load_q <= CTRL_RST[CTRL_LOAD_BIT];
      ser_en_q    <= CTRL_RST[CTRL_SEN_BIT];
    end else begin
      soft_load_q <= 1'b0;
      if (wr_pend_q && wr_addr_q == OFS_CTRL) begin
        soft_load_q <= HWDATA[CTRL_LOAD_BIT];
        ser_en_q    <= HWDATA[CTRL_SEN_BIT];
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!chan_rst_n);

  sequence s_abort;
    (ser_q == SER_SHIFT) && !frm_low;
  endsequence

  sequence s_word_in_a;
    commit && !word[CH_BIT];
  endsequence

  sequence s_load_pending_a;
    load_act && dirty_a_q;
  endsequence

  a_frame_abort: assert property (
    s_abort |=> ser_q == SER_IDLE && $stable(in_a_q)
                && $stable(in_b_q))
    else $error("Aborted frame changed state or inputs");

  a_word_done: assert property (
    commit |=> ser_q == SER_DONE && cnt_q == 5'h10)
    else $error("Sixteenth edge did not close the word");

  a_done_locked: assert property (
    (ser_q == SER_DONE && frm_low) |=> ser_q == SER_DONE
                                       && $stable(shreg_q))
    else $error("Bits accepted after sixteenth edge");

  a_commit_a: assert property (
    s_word_in_a |=> in_a_q == word_to_chan($past(word))
                    && dirty_a_q)
    else $error("Channel A input not loaded");

  a_output_hold: assert property (
    !load_act |=> $stable(out_a_q) && $stable(out_b_q))
    else $error("Output changed while load high");

  a_load_follow: assert property (
    s_load_pending_a |=> out_a_q == $past(in_a_q))
    else $error("Output did not follow input on load");

  a_no_stale: assert property (
    (load_act && !dirty_b_q) |=> $stable(out_b_q))
    else $error("Output reloaded without a new write");

  a_hard_pd: assert property (
    !hard_pd |=> PWR_MODE_A == {$past(out_a_q.pwr_mode_hi),
                                $past(out_a_q.pwr_mode_lo)})
    else $error("Mode wrong without hard power-down");

  a_hard_pd_hiz: assert property (
    hard_pd |=> PWR_MODE_A == MODE_HIZ && PWR_MODE_B == MODE_HIZ)
    else $error("Hard power-down did not force hiz");

  a_clear_zero: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    !CLEAR_ALL_N |-> in_a_q == CHAN_RST && out_b_q == CHAN_RST)
    else $error("Clear left a register nonzero");

endmodule : ddsc_top

`default_nettype wire

/* File: verification/ddsc_host.sv */
/*
  Serial host model: drives frame select, serial clock and data pins.
  Assumes the bench calls send from one process at a time and feeds
  the system clock, on whose rising edges every pin changes.
*/
`timescale 1ns/1ps
`default_nettype none

module ddsc_host (
  input  wire logic CLOCK,
  output var  logic FRAME_N,
  output var  logic SCLK_IN,
  output var  logic SDATA_IN
);

  // ****************************************************************
  // Frame driver
  // ****************************************************************
  initial begin
    FRAME_N  = 1'b1;
    SCLK_IN  = 1'b1;
    SDATA_IN = 1'b0;
  end

  // Fewer than 16 edges aborts, more adds stray edges; the serial
  // clock idles high, eight system clocks to one period
  task automatic send(input logic [15:0] w, input int n);
    @(posedge CLOCK);
    FRAME_N <= 1'b0;
    repeat (5) @(posedge CLOCK);
    for (int i = 0; i < n; i++) begin
      SDATA_IN <= (i < 16) ? w[15 - i] : ~SDATA_IN;
      repeat (4) @(posedge CLOCK);
      SCLK_IN <= 1'b0;
      repeat (4) @(posedge CLOCK);
      SCLK_IN <= 1'b1;
    end
    repeat (5) @(posedge CLOCK);
    FRAME_N <= 1'b1;
    // Released line must not show a stale bit
    SDATA_IN <= ~SDATA_IN;
  endtask : send

endmodule : ddsc_host

`default_nettype wire

/* File: verification/testbench.sv */
/*
  Self-checking bench of the converter control block.
  Assumes the serial host model and a local AHB-Lite master.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ddsc_pkg::*;

  logic        clock, rst_b, hsel, hwrite, hreadyout, hresp;
  logic        load_n, clear_n, hpd_n, frame_n, sclk, sdata;
  logic [1:0]  htrans, mode_a, mode_b;
  logic [31:0] haddr, hwdata, hrdata, seen_val;
  ddsc_chan_t  out_a, out_b;
  logic [31:0] exp_q[$];
  int          err_total, cmp_count;
  string       seen_name;
  event        seen;

  ddsc_top #(.DATA_BITS(12)) i_ddsc_top (
    .CLOCK(clock), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .FRAME_N(frame_n), .SCLK_IN(sclk), .SDATA_IN(sdata),
    .LOAD_OUTPUTS_N(load_n), .CLEAR_ALL_N(clear_n),
    .HARD_POWERDOWN_N(hpd_n), .OUT_CHAN_A(out_a), .OUT_CHAN_B(out_b),
    .PWR_MODE_A(mode_a), .PWR_MODE_B(mode_b));

  ddsc_host i_ddsc_host (.CLOCK(clock), .FRAME_N(frame_n), .SCLK_IN(sclk),
                         .SDATA_IN(sdata));

  // ****************************************************************
  // Checking and reporting
  // ****************************************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // Gap of 1 ns keeps two notes from sharing one event
  task automatic note(string nm, logic [31:0] e, logic [31:0] g);
    exp_q.push_back(e);
    seen_name = nm;
    seen_val  = g;
    -> seen;
    #1;
  endtask : note

  initial begin
    forever begin
      @(seen);
      cmp_count++;
      if (seen_val !== exp_q[0]) begin
        err_total++;
        $display("wrong value %s expected %h seen %h", seen_name,
                 exp_q[0], seen_val);
      end
      void'(exp_q.pop_front());
    end
  end

  // ****************************************************************
  // AHB-Lite master
  // ****************************************************************
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_total++;
      summarize();
    end
  endtask : wait_rdy

  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    hsel <= 1'b0;
  endtask : bus

  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    note(nm, e, r);
  endtask : rd

  // ****************************************************************
  // Clock, watchdog and scenarios
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    summarize();
  end

  initial begin
    logic [15:0] w;
    logic [14:0] cur_a;
    logic [31:0] r;
    rst_b = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0;
    hwrite = 1'b0; hwdata = '0; load_n = 1'b1; clear_n = 1'b1;
    hpd_n = 1'b1;
    cur_a = '0;
    void'($urandom(32'hdd0d_61aa));
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    rd(OFS_CTRL, 32'(CTRL_RST), "ctrl");
    note("hresp", '0, 32'(hresp));
    for (int i = 2; i < 6; i++) rd(8'(4 * i), '0, "chan reg");
    note("mode_a", '0, 32'(mode_a));
    rd(8'h40, '0, "unmapped");
    // Every mode code on channel A, random range and code
    for (int k = 0; k < 4; k++) begin
      w = 16'($urandom);
      w[15] = 1'b0;
      w[13:12] = 2'(k);
      i_ddsc_host.send(w, 16);
      repeat (8) @(posedge clock);
      rd(OFS_IN_A, 32'(w[14:0]), "in_a");
      note("out_a held", 32'(cur_a), 32'(out_a));
      @(posedge clock) load_n <= 1'b0;
      @(posedge clock) load_n <= 1'b1;
      repeat (6) @(posedge clock);
      cur_a = w[14:0];
      note("out_a", 32'(cur_a), 32'(out_a));
      note("mode_a", 32'(k), 32'(mode_a));
    end
    w = 16'($urandom) | 16'h8000;
    i_ddsc_host.send(w, 16);
    repeat (8) @(posedge clock);
    rd(OFS_STATUS, 32'h0000_0080, "pending b");
    @(posedge clock) load_n <= 1'b0;
    @(posedge clock) load_n <= 1'b1;
    repeat (6) @(posedge clock);
    note("out_b", 32'(w[14:0]), 32'(out_b));
    note("out_a kept", 32'(cur_a), 32'(out_a));
    rd(OFS_STATUS, 32'h0000_0000, "pending none");
    i_ddsc_host.send(~cur_a, 12);
    repeat (8) @(posedge clock);
    rd(OFS_IN_A, 32'(cur_a), "in_a abort");
    w = 16'($urandom) & 16'h7FFF;
    i_ddsc_host.send(w, 20);
    repeat (8) @(posedge clock);
    rd(OFS_IN_A, 32'(w[14:0]), "in_a long");
    bus(1'b1, OFS_CTRL, 32'h0000_0003, r);
    repeat (4) @(posedge clock);
    cur_a = w[14:0];
    note("out_a soft", 32'(cur_a), 32'(out_a));
    @(posedge clock) hpd_n <= 1'b0;
    repeat (6) @(posedge clock);
    note("mode_a pd", 32'(MODE_HIZ), 32'(mode_a));
    note("mode_b pd", 32'(MODE_HIZ), 32'(mode_b));
    note("out_a pd", 32'(cur_a), 32'(out_a));
    @(posedge clock) hpd_n <= 1'b1;
    repeat (6) @(posedge clock);
    note("mode_a back", 32'(cur_a[13:12]), 32'(mode_a));
    @(posedge clock) clear_n <= 1'b0;
    repeat (3) @(posedge clock);
    note("out_a clr", '0, 32'(out_a));
    note("out_b clr", '0, 32'(out_b));
    @(posedge clock) clear_n <= 1'b1;
    rd(OFS_IN_B, '0, "in_b clr");
    // Serial enable off blocks frames; a mid-run reset turns it back on
    bus(1'b1, OFS_CTRL, 32'h0000_0000, r);
    w = 16'($urandom) | 16'h0001;
    w[15] = 1'b0;
    i_ddsc_host.send(w, 16);
    repeat (8) @(posedge clock);
    rd(OFS_IN_A, '0, "in_a blocked");
    @(posedge clock) rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    rd(OFS_CTRL, 32'(CTRL_RST), "ctrl again");
    rd(OFS_OUT_A, '0, "out_a again");
    i_ddsc_host.send(w, 16);
    repeat (8) @(posedge clock);
    rd(OFS_IN_A, 32'(w[14:0]), "in_a again");
    summarize();
  end

endmodule : testbench

`default_nettype wire
